// ### dv/sscm_host_model.sv
module sscm_host_model (
  input wire logic clock,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  output logic rec_valid,
  output sscm_pkg::sscm_rec_t rec_kind,
  output logic [15:0] rec_id,
  output logic [15:0] rec_data
);
  timeunit 1ns;
  timeprecision 1ns;
  import sscm_pkg::*;
  // Idle bus and no record at time zero.
  initial begin
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    {rec_valid, rec_id, rec_data} = '0;
    rec_kind = SSCM_REC_OTHER;
  end
  // One access, held until waitrequest is sampled low; released lines
  // are inverted so stale values cannot pass for fresh ones.
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    logic busy;
    n = 0;
    busy = 1'b1;
    rd = '0;
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= wd;
    // Sample mid-cycle what the slave shows at the coming rising edge.
    do begin
      @(negedge clock);
      busy = avs_waitrequest;
      rd = avs_readdata;
      @(posedge clock);
      n++;
    end while (busy && n < 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~wd;
    if (busy) begin
      system_state_config_manager_test.n_errors++;
      system_state_config_manager_test.results();
    end
  endtask : xfer
  // One record per valid cycle; callers never put a state change in an
  // init record, and at run time only the reconfiguration target.
  task automatic rec(input sscm_rec_t k, input logic [15:0] id, d);
    @(posedge clock);
    rec_valid <= 1'b1;
    rec_kind <= k;
    rec_id <= id;
    rec_data <= d;
    @(posedge clock);
    rec_valid <= 1'b0;
    rec_id <= ~id;
    rec_data <= ~d;
  endtask : rec
endmodule : sscm_host_model

// ### dv/sscm_props.sv
module sscm_props #(
  parameter int MODE_VAR_ID = 16'h0001
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic rec_valid,
  input wire sscm_pkg::sscm_rec_t rec_kind,
  input wire logic [15:0] rec_id,
  input wire logic [15:0] rec_data,
  input wire logic run_phase,
  input wire logic [7:0] system_state,
  input wire logic load_defaults,
  input wire logic apply_config
);
  timeunit 1ns;
  timeprecision 1ns;
  import sscm_pkg::*;
  logic mode_set_reg;
  logic [7:0] mode_reg;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // Mirror of the mode variable, so the checks need no view inside.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_set_reg <= 1'b0;
      mode_reg <= 8'h00;
    end else if (!run_phase && rec_valid && rec_kind == SSCM_REC_VAR &&
                 rec_id == MODE_VAR_ID[15:0]) begin
      mode_set_reg <= 1'b1;
      mode_reg <= rec_data[7:0];
    end
  end
  // The record that closes the configuration phase.
  sequence s_end;
    !run_phase && rec_valid && rec_kind == SSCM_REC_END;
  endsequence
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("Bus answer late");
  AST_CFG_ZERO: assert property (!run_phase |-> system_state == 8'h00)
    else $error("State not zero in configuration");
  AST_AUTO: assert property (s_end ##0 (mode_set_reg && mode_reg == 8'h02)
    |=> system_state == 8'h31 ##[0:1] load_defaults)
    else $error("Automatic mode wrong");
  AST_HOST: assert property (s_end ##0 (mode_set_reg && mode_reg == 8'h03)
    |=> system_state == 8'h20 && !load_defaults && !apply_config)
    else $error("Host mode wrong");
  AST_CHANGE: assert property (s_end ##0 (mode_set_reg && mode_reg == 8'h04)
    |=> system_state == 8'h31 ##[0:1] apply_config)
    else $error("Change mode wrong");
  AST_UNSET: assert property (s_end ##0 !(mode_set_reg &&
    mode_reg inside {8'h02, 8'h03, 8'h04}) |=> system_state == 8'h05)
    else $error("Unset mode wrong");
  AST_RUN_NOW: assert property (s_end |=> run_phase)
    else $error("Run phase late");
  AST_RUN_HOLD: assert property (run_phase |=> run_phase)
    else $error("Run phase left");
  AST_QUIET_CFG: assert property (!run_phase |-> !load_defaults && !apply_config)
    else $error("Pulse during configuration");
endmodule : sscm_props

// ### dv/system_state_config_manager_test.sv
module system_state_config_manager_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sscm_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] cond = '0;
  logic [4:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, rec_valid, rec_ready;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  sscm_rec_t rec_kind;
  logic [15:0] rec_id, rec_data;
  logic run_phase, load_defaults, apply_config;
  logic [7:0] system_state;
  int n_errors = 0;
  int check_count = 0;
  // Free-running 25 MHz clock.
  always #20 clock = ~clock;
  sscm_top i_sscm_top (.clock, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .rec_valid, .rec_ready, .rec_kind, .rec_id,
    .rec_data, .zone_needs_power(cond[9]), .sensor_window_bad(cond[8]),
    .crop_window_bad(cond[7]), .compressed_out(cond[6]),
    .frame_rate_varies(cond[5]), .image_too_small(cond[4]),
    .discovery_failed(cond[3]), .bus_lock_failed(cond[2]),
    .cache_invalid(cond[1]), .cache_corrupt(cond[0]), .run_phase,
    .system_state, .load_defaults, .apply_config);
  sscm_host_model i_host (.clock, .avs_readdata, .avs_waitrequest,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .rec_valid, .rec_kind, .rec_id, .rec_data);
  task automatic check(input logic [31:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("Comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    i_host.xfer(1'b0, a, 32'h0, d);
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_host.xfer(1'b1, a, d, x);
  endtask : wr
  // Rings the doorbell and polls busy, bounded like host firmware does.
  task automatic cmd(input logic [7:0] tgt);
    logic [31:0] d;
    int n;
    wr(5'h00, {16'h0, 8'h80, tgt});
    n = 0;
    do begin
      rd(5'h00, d);
      n++;
    end while (d[15] !== 1'b0 && n < 20);
    check(d[15], 1'b0, "busy");
  endtask : cmd
  // Mode values per boot; zero stands for a mode never written.
  logic [7:0] mv [5] = '{8'h02, 8'h04, 8'h07, 8'h00, 8'h03};
  logic [7:0] es [5] = '{8'h31, 8'h31, 8'h05, 8'h05, 8'h20};
  // Conditions, camera request, payload, expected component and code.
  logic [43:0] tc [18] = '{
    {10'h200, 2'h0, 16'h02de, 16'h0201}, {10'h100, 2'h0, 16'h02de, 16'h0501},
    {10'h080, 2'h0, 16'h02de, 16'h0502}, {10'h020, 2'h0, 16'h02de, 16'h0000},
    {10'h060, 2'h0, 16'h02de, 16'h0518}, {10'h050, 2'h0, 16'h02de, 16'h0519},
    {10'h008, 2'h0, 16'h02de, 16'h0701}, {10'h004, 2'h0, 16'h02de, 16'h0708},
    {10'h002, 2'h0, 16'h02de, 16'h0f03}, {10'h001, 2'h0, 16'h02de, 16'h0f04},
    {10'h201, 2'h0, 16'h02de, 16'h0201}, {10'h000, 2'h0, 16'h02e0, 16'h0c0a},
    {10'h000, 2'h0, 16'h02dd, 16'h0c0c}, {10'h000, 2'h1, 16'h02de, 16'h0000},
    {10'h000, 2'h2, 16'h02de, 16'h050e}, {10'h000, 2'h0, 16'h02de, 16'h0000},
    {10'h000, 2'h2, 16'h02de, 16'h0000}, {10'h000, 2'h1, 16'h02de, 16'h050f}};
  // Boots once per mode, then runs a sequence reconfiguration and commands to the idle state.
  initial begin
    logic [31:0] d;
    logic [7:0] st;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      i_host.rec(SSCM_REC_OTHER, 16'h0000, 16'h0005);
      if (mv[i] != 8'h00) i_host.rec(SSCM_REC_VAR, 16'h0001, {8'h0, mv[i]});
      i_host.rec(SSCM_REC_VAR, 16'h0002, 16'h0003);
      rd(5'h10, d);
      check(d, 32'h0, "config state");
      i_host.rec(SSCM_REC_END, 16'h0000, 16'h0000);
      rd(5'h10, d);
      check(d, {23'h0, 1'b1, es[i]}, "boot state");
      i_host.rec(SSCM_REC_VAR, 16'h0001, 16'h0002);
      rd(5'h1c, d);
      if (mv[i] != 8'h00) check(d, {23'h0, 1'b1, mv[i]}, "mode");
    end
    i_host.rec(SSCM_REC_CMD, 16'h0000, 16'h0028);
    rd(5'h10, d);
    check(d, 32'h0131, "sequence reconfig");
    rd(5'h02, d);
    check(d, 32'h0, "unmapped");
    st = 8'h31;
    for (int i = 0; i < 18; i++) begin
      cond <= tc[i][43:34];
      wr(5'h14, {16'h0, tc[i][31:16]});
      wr(5'h18, {30'h0, tc[i][33:32]});
      cmd(8'h20);
      if (tc[i][15:8] == 8'h00) st = 8'h20;
      rd(5'h04, d);
      check(d, (tc[i][15:8] != 8'h00) ? 32'h0c : 32'h0, "result");
      rd(5'h08, d);
      check(d, {24'h0, tc[i][15:8]}, "component");
      rd(5'h0c, d);
      check(d, {24'h0, tc[i][7:0]}, "code");
      rd(5'h10, d);
      check(d, {24'h01, st}, "state");
    end
    results();
  end
endmodule : system_state_config_manager_test
bind sscm_top sscm_props #(.MODE_VAR_ID(MODE_VAR_ID)) i_sscm_props (
  .clock, .reset_n, .avs_read, .avs_write, .avs_waitrequest, .rec_valid,
  .rec_kind, .rec_id, .rec_data, .run_phase, .system_state,
  .load_defaults, .apply_config);

// ### hdl/sscm_consts.svh
`ifndef SSCM_CONSTS_SVH
`define SSCM_CONSTS_SVH
// Register byte offsets.
`define SSCM_OFS_CMD 5'h00
`define SSCM_OFS_RESULT 5'h04
`define SSCM_OFS_COMP 5'h08
`define SSCM_OFS_FAIL 5'h0c
`define SSCM_OFS_STATE 5'h10
`define SSCM_OFS_PAYLOAD 5'h14
`define SSCM_OFS_CAMMODE 5'h18
`define SSCM_OFS_MODESEL 5'h1c
// Command register fields.
`define SSCM_BELL_BIT 15
// Post-configuration mode values.
`define SSCM_MODE_AUTO 8'h02
`define SSCM_MODE_HOST 8'h03
`define SSCM_MODE_CHANGE 8'h04
// System states.
`define SSCM_ST_RESET 8'h00
`define SSCM_ST_CFG_DONE 8'h05
`define SSCM_ST_IDLE 8'h20
`define SSCM_ST_RECONF 8'h28
`define SSCM_ST_STREAM 8'h31
// Result status values.
`define SSCM_RES_OK 16'h0000
`define SSCM_RES_REJECT 16'h000c
// Rejecting component identifiers.
`define SSCM_CID_NONE 16'h0000
`define SSCM_CID_DEV 16'h0002
`define SSCM_CID_CAM 16'h0005
`define SSCM_CID_SENS 16'h0007
`define SSCM_CID_TX 16'h000c
`define SSCM_CID_STE 16'h000f
`define SSCM_CID_RX 16'h0010
// Component failure codes.
`define SSCM_F_DEV_ZONE 16'h0001
`define SSCM_F_CAM_SWIN 16'h0001
`define SSCM_F_CAM_CROP 16'h0002
`define SSCM_F_CAM_SYNC_EXIT 16'h000e
`define SSCM_F_CAM_SYNC_ENTRY 16'h000f
`define SSCM_F_CAM_RATE 16'h0018
`define SSCM_F_CAM_SMALL 16'h0019
`define SSCM_F_SENS_DISC 16'h0001
`define SSCM_F_SENS_LOCK 16'h0008
`define SSCM_F_TX_BIG 16'h000a
`define SSCM_F_TX_ODD 16'h000c
`define SSCM_F_STE_INVAL 16'h0003
`define SSCM_F_STE_CORRUPT 16'h0004
// Largest packet payload in 16-bit words.
`define SSCM_PAYLOAD_MAX 16'd734
`endif

// ### hdl/sscm_pkg.sv
package sscm_pkg;
  // Kinds of record delivered from non-volatile memory.
  typedef enum logic [1:0] {
    SSCM_REC_VAR,
    SSCM_REC_CMD,
    SSCM_REC_END,
    SSCM_REC_OTHER
  } sscm_rec_t;
  // Camera operating modes.
  typedef enum logic [1:0] {
    SSCM_CAM_NORMAL,
    SSCM_CAM_SYNC,
    SSCM_CAM_OTHER,
    SSCM_CAM_SPARE
  } sscm_cam_t;
  // Device phases.
  typedef enum logic {
    SSCM_PH_CONFIG,
    SSCM_PH_RUN
  } sscm_phase_t;
endpackage : sscm_pkg

// ### hdl/sscm_top.sv
// Notes on behaviour
// - Reset enters the configuration phase first.
// - Init records are handled one at a time.
// - Mode 2 loads default settings, then streams.
// - Mode 3 goes to idle state 0x20.
// - Mode 4 applies configuration, then streams.
// - Mode is evaluated only after all tables.
// - Unset mode goes to state 5.
// - Mode variable is read-only after configuration.
// - Run-time phase follows configuration immediately.
// - Each command reports status, component, code.
// - Component identifiers use the fixed codes.
// - Device manager rejects needed-zone power off.
// - Camera rejects bad sensor or crop windows.
// - Synchronized mode only from or to normal.
// - Compressed video needs constant rate, size.
// - Sensor manager reports discovery and lock failure.
// - Payload above 734 or odd is rejected.
// - Transform cache invalid or corrupt reported.
`include "sscm_consts.svh"
module sscm_top #(
  parameter int MODE_VAR_ID = 16'h0001
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rec_valid,
  output logic rec_ready,
  input wire sscm_pkg::sscm_rec_t rec_kind,
  input wire logic [15:0] rec_id,
  input wire logic [15:0] rec_data,
  input wire logic zone_needs_power,
  input wire logic sensor_window_bad,
  input wire logic crop_window_bad,
  input wire logic compressed_out,
  input wire logic frame_rate_varies,
  input wire logic image_too_small,
  input wire logic discovery_failed,
  input wire logic bus_lock_failed,
  input wire logic cache_invalid,
  input wire logic cache_corrupt,
  output logic run_phase,
  output logic [7:0] system_state,
  output logic load_defaults,
  output logic apply_config
);
  import sscm_pkg::*;

  sscm_phase_t phase_reg;
  logic [7:0] state_reg;
  logic [7:0] mode_reg;
  logic mode_set_reg;
  logic [15:0] result_reg;
  logic [15:0] comp_reg;
  logic [15:0] fail_reg;
  logic [15:0] payload_reg;
  sscm_cam_t cam_cur_reg;
  sscm_cam_t cam_req_reg;
  logic bell_reg;
  logic [7:0] target_reg;
  logic eval_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic load_reg;
  logic apply_reg;

  logic access;
  logic wr_en;
  logic cfg_end;
  logic seq_cmd;
  logic host_go;
  logic [15:0] chk_comp;
  logic [15:0] chk_fail;

  // One wait cycle per access lets read data come from a flip-flop.
  assign access = avs_read | avs_write;
  assign avs_waitrequest = access & ~ack_reg;
  // Writes land at the edge where waitrequest is seen low.
  assign wr_en = avs_write & ack_reg & avs_byteenable[0];
  assign avs_readdata = rdata_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access & ~ack_reg;
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      unique case (avs_address)
        `SSCM_OFS_CMD:
          rdata_reg <= {16'h0000, bell_reg, 7'h00, target_reg};
        `SSCM_OFS_RESULT: rdata_reg <= {16'h0000, result_reg};
        `SSCM_OFS_COMP: rdata_reg <= {16'h0000, comp_reg};
        `SSCM_OFS_FAIL: rdata_reg <= {16'h0000, fail_reg};
        `SSCM_OFS_STATE:
          rdata_reg <= {23'h000000, phase_reg, state_reg};
        `SSCM_OFS_PAYLOAD: rdata_reg <= {16'h0000, payload_reg};
        `SSCM_OFS_CAMMODE:
          rdata_reg <= {28'h0000000, cam_cur_reg, cam_req_reg};
        `SSCM_OFS_MODESEL:
          rdata_reg <= {23'h000000, mode_set_reg, mode_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Records are taken one per cycle and acted on only while configuring or for
  // command sequences at run time; rec_ready stays high, so none is held.
  assign rec_ready = 1'b1;
  assign cfg_end = rec_valid && rec_kind == SSCM_REC_END
    && phase_reg == SSCM_PH_CONFIG;
  // A state change from a stored sequence is honoured only for
  // reconfiguration; other targets are dropped rather than executed.
  assign seq_cmd = rec_valid && rec_kind == SSCM_REC_CMD
    && phase_reg == SSCM_PH_RUN
    && rec_data[7:0] == `SSCM_ST_RECONF && !eval_reg;
  assign host_go = bell_reg && !eval_reg
    && phase_reg == SSCM_PH_RUN;

  // Phase starts in configuration and flips once, with no gap.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= SSCM_PH_CONFIG;
    end else if (cfg_end) begin
      phase_reg <= SSCM_PH_RUN;
    end
  end

  // Mode variable is written only by records during configuration;
  // command records in that phase are ignored.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= 8'h00;
      mode_set_reg <= 1'b0;
    end else if (rec_valid && rec_kind == SSCM_REC_VAR
        && rec_id == MODE_VAR_ID[15:0]
        && phase_reg == SSCM_PH_CONFIG) begin
      mode_reg <= rec_data[7:0];
      mode_set_reg <= 1'b1;
    end
  end

  // Camera configuration values, writable by software.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      payload_reg <= 16'h0000;
      cam_req_reg <= SSCM_CAM_NORMAL;
    end else if (wr_en) begin
      if (avs_address == `SSCM_OFS_PAYLOAD && avs_byteenable[1]) begin
        payload_reg <= avs_writedata[15:0];
      end
      if (avs_address == `SSCM_OFS_CAMMODE) begin
        cam_req_reg <= sscm_cam_t'(avs_writedata[1:0]);
      end
    end
  end

  // Doorbell: software sets it, the device clears it when done.
  // A new ring is only taken while the bell is low, and then wins over a clear in the same cycle.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bell_reg <= 1'b0;
      target_reg <= 8'h00;
    end else if (wr_en && avs_address == `SSCM_OFS_CMD
        && avs_byteenable[1] && avs_writedata[`SSCM_BELL_BIT]
        && !bell_reg) begin
      bell_reg <= 1'b1;
      target_reg <= avs_writedata[7:0];
    end else if (seq_cmd && !bell_reg) begin
      target_reg <= `SSCM_ST_RECONF;
    end else if (eval_reg) begin
      bell_reg <= 1'b0;
    end
  end

  // Checks in fixed priority; first failing component is reported.
  always_comb begin
    chk_comp = `SSCM_CID_NONE;
    chk_fail = 16'h0000;
    if (zone_needs_power) begin
      chk_comp = `SSCM_CID_DEV;
      chk_fail = `SSCM_F_DEV_ZONE;
    end else if (sensor_window_bad) begin
      chk_comp = `SSCM_CID_CAM;
      chk_fail = `SSCM_F_CAM_SWIN;
    end else if (crop_window_bad) begin
      chk_comp = `SSCM_CID_CAM;
      chk_fail = `SSCM_F_CAM_CROP;
    end else if (cam_cur_reg == SSCM_CAM_SYNC
        && cam_req_reg != SSCM_CAM_SYNC
        && cam_req_reg != SSCM_CAM_NORMAL) begin
      chk_comp = `SSCM_CID_CAM;
      chk_fail = `SSCM_F_CAM_SYNC_EXIT;
    end else if (cam_req_reg == SSCM_CAM_SYNC
        && cam_cur_reg != SSCM_CAM_SYNC
        && cam_cur_reg != SSCM_CAM_NORMAL) begin
      chk_comp = `SSCM_CID_CAM;
      chk_fail = `SSCM_F_CAM_SYNC_ENTRY;
    end else if (compressed_out && frame_rate_varies) begin
      chk_comp = `SSCM_CID_CAM;
      chk_fail = `SSCM_F_CAM_RATE;
    end else if (compressed_out && image_too_small) begin
      chk_comp = `SSCM_CID_CAM;
      chk_fail = `SSCM_F_CAM_SMALL;
    end else if (discovery_failed) begin
      chk_comp = `SSCM_CID_SENS;
      chk_fail = `SSCM_F_SENS_DISC;
    end else if (bus_lock_failed) begin
      chk_comp = `SSCM_CID_SENS;
      chk_fail = `SSCM_F_SENS_LOCK;
    end else if (payload_reg > `SSCM_PAYLOAD_MAX) begin
      chk_comp = `SSCM_CID_TX;
      chk_fail = `SSCM_F_TX_BIG;
    end else if (payload_reg[0]) begin
      chk_comp = `SSCM_CID_TX;
      chk_fail = `SSCM_F_TX_ODD;
    end else if (cache_invalid) begin
      chk_comp = `SSCM_CID_STE;
      chk_fail = `SSCM_F_STE_INVAL;
    end else if (cache_corrupt) begin
      chk_comp = `SSCM_CID_STE;
      chk_fail = `SSCM_F_STE_CORRUPT;
    end
  end

  // Evaluation flag marks the single cycle in which results land.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      eval_reg <= 1'b0;
    end else begin
      eval_reg <= host_go || (seq_cmd && !bell_reg);
    end
  end

  // Result registers update one cycle before the doorbell drops.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= `SSCM_RES_OK;
      comp_reg <= `SSCM_CID_NONE;
      fail_reg <= 16'h0000;
    end else if (host_go || (seq_cmd && !bell_reg)) begin
      comp_reg <= chk_comp;
      fail_reg <= chk_fail;
      result_reg <= (chk_comp == `SSCM_CID_NONE) ?
        `SSCM_RES_OK : `SSCM_RES_REJECT;
    end
  end

  // System state: set once at the end of configuration from the mode
  // variable, then by accepted state-change commands.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= `SSCM_ST_RESET;
      cam_cur_reg <= SSCM_CAM_NORMAL;
    end else if (cfg_end) begin
      if (mode_set_reg && mode_reg == `SSCM_MODE_AUTO) begin
        state_reg <= `SSCM_ST_STREAM;
      end else if (mode_set_reg && mode_reg == `SSCM_MODE_HOST) begin
        state_reg <= `SSCM_ST_IDLE;
      end else if (mode_set_reg && mode_reg == `SSCM_MODE_CHANGE) begin
        state_reg <= `SSCM_ST_STREAM;
      end else begin
        state_reg <= `SSCM_ST_CFG_DONE;
      end
    end else if (eval_reg && comp_reg == `SSCM_CID_NONE) begin
      // Reconfiguration completes straight into streaming.
      state_reg <= (target_reg == `SSCM_ST_RECONF) ?
        `SSCM_ST_STREAM : target_reg;
      cam_cur_reg <= cam_req_reg;
    end
  end

  // One-cycle pulses that drive the rest of the chip.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      load_reg <= 1'b0;
      apply_reg <= 1'b0;
    end else begin
      load_reg <= cfg_end && mode_set_reg
        && mode_reg == `SSCM_MODE_AUTO;
      apply_reg <= (cfg_end && mode_set_reg
        && mode_reg == `SSCM_MODE_CHANGE)
        || (eval_reg && comp_reg == `SSCM_CID_NONE
        && target_reg == `SSCM_ST_RECONF);
    end
  end

  assign run_phase = (phase_reg == SSCM_PH_RUN);
  assign system_state = state_reg;
  assign load_defaults = load_reg;
  assign apply_config = apply_reg;
endmodule : sscm_top
